//--- hdl/fsdt_timer_bank.sv
// Bank of 4096 down-counting timers behind an APB3 slave port.
// Assumes APB master on CLOCK_I, tick periods below 65536 cycles.
//
// Notes on behaviour
// - 1 ms variant counts down one per elapsed 1 ms tick while running.
// - 0.1 ms variant counts down one per elapsed 0.1 ms tick.
// - 0.01 ms variant counts down one per elapsed 0.01 ms tick.
// - Run going true starts the timer from the preset.
// - Count keeps falling each tick while run stays true.
// - Count at zero raises the completion flag while run is true.
// - Any nonzero count keeps the completion flag low.
// - Run false loads preset into count and clears the flag.
// - 1 ms timers 0 to 15 count on their own every tick.
// - 1 ms timers 16 and up move only when operated.
// - Compatibility option: low 1 ms timers update at cycle end.
`timescale 1ns/1ps
`default_nettype none

module fsdt_timer_bank #(
  parameter int unsigned ONE_MS_CYCLES = fsdt_pkg::ONE_MS_CYC,
  parameter int unsigned TENTH_MS_CYCLES = fsdt_pkg::TENTH_MS_CYC,
  parameter int unsigned HUNDREDTH_MS_CYCLES = fsdt_pkg::HUNDREDTH_MS_CYC
) (
  input wire logic CLOCK_I,
  input wire logic NRST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O
);

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [15:0] period_of(input int unsigned v);
    case (v)
      0: period_of = 16'(ONE_MS_CYCLES);
      1: period_of = 16'(TENTH_MS_CYCLES);
      default: period_of = 16'(HUNDREDTH_MS_CYCLES);
    endcase
  endfunction

  // Saturating step, so a finished timer rests at zero
  function automatic logic [15:0] sat_sub(input logic [15:0] a,
                                          input logic [15:0] b);
    sat_sub = (a > b) ? (a - b) : 16'h0000;
  endfunction

  function automatic logic [31:0] entry_word(
      input fsdt_pkg::fsdt_entry_t e);
    entry_word = 32'h0000_0000;
    entry_word[15:0] = e.present_count;
    entry_word[fsdt_pkg::STAT_DONE_BIT] = e.done;
    entry_word[fsdt_pkg::STAT_RUN_BIT] = e.run;
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    case (a)
      fsdt_pkg::OFS_CMD, fsdt_pkg::OFS_RESULT, fsdt_pkg::OFS_PEEK_SEL,
      fsdt_pkg::OFS_PEEK, fsdt_pkg::OFS_CONFIG,
      fsdt_pkg::OFS_CYCLE_END: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Free-running time bases, one per tick unit

  logic [15:0] pre_cnt [fsdt_pkg::NUM_BASES];
  logic [15:0] now [fsdt_pkg::NUM_BASES];
  logic tick [fsdt_pkg::NUM_BASES];

  for (genvar v = 0; v < fsdt_pkg::NUM_BASES; v++) begin : g_base
    // Tick pulse and tick count change on the same edge
    always_ff @(posedge CLOCK_I) begin
      if (!NRST_I) begin
        pre_cnt[v] <= 16'h0000;
        now[v] <= 16'h0000;
        tick[v] <= 1'b0;
      end else if (pre_cnt[v] == period_of(v) - 16'h0001) begin
        pre_cnt[v] <= 16'h0000;
        now[v] <= now[v] + 16'h0001;
        tick[v] <= 1'b1;
      end else begin
        pre_cnt[v] <= pre_cnt[v] + 16'h0001;
        tick[v] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB decode; writes act on the edge that completes the transfer

  logic wr_fire;
  logic exec;
  logic cycle_end;
  fsdt_pkg::fsdt_cmd_t cmd;
  logic compat;
  logic [11:0] peek_idx;

  assign wr_fire = PSEL_I & PENABLE_I & PREADY_O & PWRITE_I;
  assign cmd.run = PWDATA_I[fsdt_pkg::CMD_RUN_BIT];
  assign cmd.variant = fsdt_pkg::fsdt_variant_t'(
    PWDATA_I[fsdt_pkg::CMD_VAR_LSB +: 2]);
  assign cmd.idx = PWDATA_I[fsdt_pkg::CMD_IDX_LSB +: 12];
  assign cmd.preset = PWDATA_I[fsdt_pkg::CMD_PRESET_LSB +: 16];
  assign exec = wr_fire && (PADDR_I == fsdt_pkg::OFS_CMD) &&
                (cmd.variant != fsdt_pkg::FSDT_VARIANT_BAD);
  assign cycle_end = wr_fire && (PADDR_I == fsdt_pkg::OFS_CYCLE_END);

  // One wait state so read data and error come from flip-flops
  always_ff @(posedge CLOCK_I) begin
    if (!NRST_I) begin
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
    end else begin
      PREADY_O <= PSEL_I & PENABLE_I & ~PREADY_O;
      PSLVERR_O <= PSEL_I & PENABLE_I & ~PREADY_O & (~is_mapped(PADDR_I) |
        (PWRITE_I & (PADDR_I == fsdt_pkg::OFS_CMD) &
         (PWDATA_I[fsdt_pkg::CMD_VAR_LSB +: 2] == 2'b11)));
    end
  end

  // Configuration and peek selector
  always_ff @(posedge CLOCK_I) begin
    if (!NRST_I) begin
      compat <= fsdt_pkg::CFG_COMPAT_RESET;
      peek_idx <= fsdt_pkg::PEEK_SEL_RESET;
    end else if (wr_fire && PADDR_I == fsdt_pkg::OFS_CONFIG) begin
      compat <= PWDATA_I[fsdt_pkg::CFG_COMPAT_BIT];
    end else if (wr_fire && PADDR_I == fsdt_pkg::OFS_PEEK_SEL) begin
      peek_idx <= PWDATA_I[11:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Timer operation on the selected entry

  fsdt_pkg::fsdt_entry_t ent [fsdt_pkg::NUM_TIMERS];
  fsdt_pkg::fsdt_entry_t sel;
  fsdt_pkg::fsdt_entry_t next_sel;
  fsdt_pkg::fsdt_entry_t res;
  logic [15:0] now_sel;
  logic [15:0] step;
  logic auto_own;

  assign sel = ent[cmd.idx];
  assign now_sel = (cmd.variant == fsdt_pkg::FSDT_VARIANT_BAD) ?
                   now[0] : now[cmd.variant];
  assign auto_own = (cmd.idx < 12'(fsdt_pkg::AUTO_TIMERS)) &&
                    (cmd.variant == fsdt_pkg::FSDT_ONE_MS_DOWN_TIMER);

  // Non-autonomous timers catch up by the ticks since their last
  // visit; a 16-bit stamp limits the gap to 65535 ticks
  always_comb begin
    next_sel = sel;
    step = 16'h0000;
    if (!cmd.run) begin
      next_sel.run = 1'b0;
      next_sel.variant = cmd.variant;
      next_sel.present_count = cmd.preset;
      next_sel.done = 1'b0;
      next_sel.stamp = now_sel;
    end else if (!sel.run || sel.variant != cmd.variant) begin
      next_sel.run = 1'b1;
      next_sel.variant = cmd.variant;
      next_sel.present_count = cmd.preset;
      next_sel.done = (cmd.preset == 16'h0000);
      next_sel.stamp = now_sel;
    end else begin
      if (auto_own) begin
        // Own tick is blocked this cycle, so take it here
        step = (tick[0] && !compat) ? 16'h0001 : 16'h0000;
      end else begin
        step = now_sel - sel.stamp;
        next_sel.stamp = now_sel;
      end
      next_sel.present_count = sat_sub(sel.present_count, step);
      next_sel.done = (sat_sub(sel.present_count, step) == 16'h0000);
    end
  end

  // Autonomous update of the low timers
  function automatic fsdt_pkg::fsdt_entry_t auto_step(
      input fsdt_pkg::fsdt_entry_t e, input logic cmp, input logic t,
      input logic ce, input logic [15:0] n);
    auto_step = e;
    if (e.run && e.variant == fsdt_pkg::FSDT_ONE_MS_DOWN_TIMER) begin
      if (cmp && ce) begin
        auto_step.present_count = sat_sub(e.present_count, n - e.stamp);
        auto_step.stamp = n;
      end else if (!cmp && t) begin
        auto_step.present_count = sat_sub(e.present_count, 16'h0001);
      end
      auto_step.done = (auto_step.present_count == 16'h0000);
    end
  endfunction

  for (genvar i = 0; i < fsdt_pkg::NUM_TIMERS; i++) begin : g_timer
    always_ff @(posedge CLOCK_I) begin
      if (!NRST_I) begin
        ent[i] <= fsdt_pkg::ENTRY_RESET;
      end else if (exec && cmd.idx == 12'(i)) begin
        ent[i] <= next_sel;
      end else if (i < fsdt_pkg::AUTO_TIMERS) begin
        ent[i] <= auto_step(ent[i], compat, tick[0], cycle_end, now[0]);
      end
    end
  end

  // Result of the last operation, read back one transfer later
  always_ff @(posedge CLOCK_I) begin
    if (!NRST_I) begin
      res <= fsdt_pkg::ENTRY_RESET;
    end else if (exec) begin
      res <= next_sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data, sampled in the first access cycle

  always_ff @(posedge CLOCK_I) begin
    if (!NRST_I) begin
      PRDATA_O <= fsdt_pkg::RDATA_RESET;
    end else if (PSEL_I & PENABLE_I & ~PREADY_O & ~PWRITE_I) begin
      case (PADDR_I)
        fsdt_pkg::OFS_RESULT: PRDATA_O <= entry_word(res);
        fsdt_pkg::OFS_PEEK_SEL: PRDATA_O <= {20'h0_0000, peek_idx};
        fsdt_pkg::OFS_PEEK: PRDATA_O <= entry_word(ent[peek_idx]);
        fsdt_pkg::OFS_CONFIG: PRDATA_O <= {31'h0000_0000, compat};
        default: PRDATA_O <= fsdt_pkg::RDATA_RESET;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  logic [15:0] gap [fsdt_pkg::NUM_BASES];
  logic seen [fsdt_pkg::NUM_BASES];

  for (genvar v = 0; v < fsdt_pkg::NUM_BASES; v++) begin : g_chk
    // Cycles since the previous tick of this base
    always_ff @(posedge CLOCK_I) begin
      if (!NRST_I) begin
        gap[v] <= 16'h0000;
        seen[v] <= 1'b0;
      end else if (tick[v]) begin
        gap[v] <= 16'h0000;
        seen[v] <= 1'b1;
      end else begin
        gap[v] <= gap[v] + 16'h0001;
      end
    end

    property p_tick_period;
      @(posedge CLOCK_I) disable iff (!NRST_I)
      (tick[v] && seen[v]) |-> (gap[v] == period_of(v) - 16'h0001);
    endproperty
    a_tick_period: assert property (p_tick_period)
      else $error("tick period wrong");
  end

  sequence s_cmd_stop;
    exec && !cmd.run;
  endsequence

  sequence s_cmd_start;
    exec && cmd.run && !sel.run;
  endsequence

  property p_stop_loads;
    @(posedge CLOCK_I) disable iff (!NRST_I)
    s_cmd_stop |=> (res.present_count == $past(cmd.preset)) && !res.done
      && !res.run;
  endproperty
  a_stop_loads: assert property (p_stop_loads)
    else $error("stop did not load preset");

  property p_start_loads;
    @(posedge CLOCK_I) disable iff (!NRST_I)
    s_cmd_start |=> res.run && (res.present_count == $past(cmd.preset));
  endproperty
  a_start_loads: assert property (p_start_loads)
    else $error("start did not load preset");

  property p_zero_preset;
    @(posedge CLOCK_I) disable iff (!NRST_I)
    (s_cmd_start and (cmd.preset == 16'h0000)) |=> res.done;
  endproperty
  a_zero_preset: assert property (p_zero_preset)
    else $error("zero preset not done");

  property p_done_matches;
    @(posedge CLOCK_I) disable iff (!NRST_I)
    ent[0].run |-> (ent[0].done == (ent[0].present_count == 16'h0000));
  endproperty
  a_done_matches: assert property (p_done_matches)
    else $error("flag disagrees with count");

  property p_auto_dec;
    @(posedge CLOCK_I) disable iff (!NRST_I)
    (tick[0] && !compat && !(exec && cmd.idx == 12'h000) && ent[0].run &&
     ent[0].variant == fsdt_pkg::FSDT_ONE_MS_DOWN_TIMER &&
     ent[0].present_count != 16'h0000)
    |=> ent[0].present_count == $past(ent[0].present_count) - 16'h0001;
  endproperty
  a_auto_dec: assert property (p_auto_dec)
    else $error("low timer missed its tick");

  property p_no_wrap;
    @(posedge CLOCK_I) disable iff (!NRST_I)
    (ent[0].run && ent[0].present_count == 16'h0000 &&
     !(exec && cmd.idx == 12'h000)) |=> ent[0].present_count == 16'h0000;
  endproperty
  a_no_wrap: assert property (p_no_wrap)
    else $error("count left zero");

  property p_high_hold;
    @(posedge CLOCK_I) disable iff (!NRST_I)
    !(exec && cmd.idx == 12'h010) |=> $stable(ent[16]);
  endproperty
  a_high_hold: assert property (p_high_hold)
    else $error("high timer moved without operation");

  property p_compat_hold;
    @(posedge CLOCK_I) disable iff (!NRST_I)
    (compat && !cycle_end && !(exec && cmd.idx == 12'h000))
    |=> $stable(ent[0].present_count);
  endproperty
  a_compat_hold: assert property (p_compat_hold)
    else $error("compat timer moved outside cycle end");

  sequence s_access_wait;
    PSEL_I && PENABLE_I && !PREADY_O;
  endsequence

  property p_apb_ready;
    @(posedge CLOCK_I) disable iff (!NRST_I)
    s_access_wait |=> PREADY_O ##1 !PREADY_O;
  endproperty
  a_apb_ready: assert property (p_apb_ready)
    else $error("ready not one cycle after access");

endmodule

`default_nettype wire

//--- inc/fsdt_pkg.sv
// Shared constants and types for the fine step down timer bank.
// Assumes a single 50 MHz clock and an APB3 register port.
package fsdt_pkg;

  // Clock and tick base, times in ns as printed, cycles derived
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned ONE_MS_NS = 1_000_000;
  localparam int unsigned TENTH_MS_NS = 100_000;
  localparam int unsigned HUNDREDTH_MS_NS = 10_000;
  localparam int unsigned ONE_MS_CYC = (ONE_MS_NS + CLK_PERIOD_NS - 1)
    / CLK_PERIOD_NS;
  localparam int unsigned TENTH_MS_CYC = (TENTH_MS_NS + CLK_PERIOD_NS - 1)
    / CLK_PERIOD_NS;
  localparam int unsigned HUNDREDTH_MS_CYC =
    (HUNDREDTH_MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Bank shape
  localparam int unsigned NUM_TIMERS = 4096;
  localparam int unsigned AUTO_TIMERS = 16;
  localparam int unsigned NUM_BASES = 3;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned IDX_W = 12;
  localparam int unsigned ADDR_W = 8;

  // Register byte offsets
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_RESULT = 8'h04;
  localparam logic [7:0] OFS_PEEK_SEL = 8'h08;
  localparam logic [7:0] OFS_PEEK = 8'h0C;
  localparam logic [7:0] OFS_CONFIG = 8'h10;
  localparam logic [7:0] OFS_CYCLE_END = 8'h14;

  // Field positions
  localparam int unsigned CMD_PRESET_LSB = 0;
  localparam int unsigned CMD_IDX_LSB = 16;
  localparam int unsigned CMD_VAR_LSB = 28;
  localparam int unsigned CMD_RUN_BIT = 30;
  localparam int unsigned STAT_DONE_BIT = 16;
  localparam int unsigned STAT_RUN_BIT = 17;
  localparam int unsigned CFG_COMPAT_BIT = 0;

  // Values after reset
  localparam logic CFG_COMPAT_RESET = 1'b0;
  localparam logic [11:0] PEEK_SEL_RESET = 12'h000;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {
    FSDT_ONE_MS_DOWN_TIMER = 2'b00,
    FSDT_TENTH_MS_DOWN_TIMER = 2'b01,
    FSDT_HUNDREDTH_MS_DOWN_TIMER = 2'b10,
    FSDT_VARIANT_BAD = 2'b11
  } fsdt_variant_t;

  typedef struct packed {
    logic run;
    fsdt_variant_t variant;
    logic done;
    logic [15:0] present_count;
    logic [15:0] stamp;
  } fsdt_entry_t;

  typedef struct packed {
    logic run;
    fsdt_variant_t variant;
    logic [11:0] idx;
    logic [15:0] preset;
  } fsdt_cmd_t;

  localparam fsdt_entry_t ENTRY_RESET = '{
    run: 1'b0, variant: FSDT_ONE_MS_DOWN_TIMER, done: 1'b0,
    present_count: 16'h0000, stamp: 16'h0000};

endpackage

//--- tb/fsdt_timer_bank_bench.sv
// Self-checking bench for the fine step down timer bank.
// Assumes one APB wait state and shortened tick periods.
`timescale 1ns/1ps
`default_nettype none

module fsdt_timer_bank_bench;
  localparam int P0 = 40;
  localparam int P1 = 20;
  localparam int P2 = 10;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [31:0] rd;
  logic err;
  logic [31:0] lfsr_q = 32'h0000_69c5;
  int fails = 0;
  int tests_run = 0;
  int cyc = 0;
  int done_cyc = 0;
  int per [3] = '{P0, P1, P2};
  int m_cnt [4096];
  int m_var [4096];
  int m_stamp [4096];
  bit m_run [4096];
  bit compat = 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // Clock, edge counter and design
  always #10 clk = ~clk;

  // Edge count since release, the model's time base
  always @(posedge clk) begin
    if (!nrst) begin
      cyc <= 0;
    end else begin
      cyc <= cyc + 1;
    end
  end

  fsdt_timer_bank #(
    .ONE_MS_CYCLES(P0),
    .TENTH_MS_CYCLES(P1),
    .HUNDREDTH_MS_CYCLES(P2)
  ) fsdt_timer_bank_inst (
    .CLOCK_I(clk),
    .NRST_I(nrst),
    .PSEL_I(psel),
    .PENABLE_I(penable),
    .PWRITE_I(pwrite),
    .PADDR_I(paddr),
    .PWDATA_I(pwdata),
    .PRDATA_O(prdata),
    .PREADY_O(pready),
    .PSLVERR_O(pslverr)
  );

  ////////////////////////////////////////////////////////////////////////
  // Reporting
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check_word(input string nm, input logic [31:0] e,
                            input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic check_bit(input string nm, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Model of the timers, counts in whole ticks
  function automatic int sat(input int x);
    return (x < 0) ? 0 : x;
  endfunction

  // Only low one-ms timers move between operations
  function automatic int live(input int i, input int c);
    int t;
    t = c / per[m_var[i]];
    if (m_run[i] && m_var[i] == 0 && i < 16 && !compat) begin
      return sat(m_cnt[i] - (t - m_stamp[i]));
    end
    return m_cnt[i];
  endfunction

  function automatic logic [31:0] word(input int i, input int c);
    int n;
    n = live(i, c);
    return {14'h0000, m_run[i], m_run[i] && n == 0, n[15:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Bus and scenario helpers
  // Holds the request until pready is sampled high, bounded wait
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fails++;
      conclude();
    end
    rd = prdata;
    err = pslverr;
    done_cyc = cyc;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Land the sampling edge mid-period, away from tick boundaries
  task automatic align(input int p, input int off);
    do begin
      @(posedge clk);
    end while ((cyc + off) % p != p / 2);
  endtask

  // Gaps stay far below the 16-bit tick stamp range
  task automatic wait_ticks(input int v, input int n);
    repeat (n * per[v]) @(posedge clk);
  endtask

  task automatic do_cmd(input bit run, input int v, input int i,
                        input int pre);
    fsdt_pkg::fsdt_cmd_t c;
    int t;
    logic [31:0] e;
    c = '{run: run, variant: fsdt_pkg::fsdt_variant_t'(v[1:0]),
          idx: i[11:0], preset: pre[15:0]};
    align(per[v], 4);
    apb(1'b1, fsdt_pkg::OFS_CMD, {1'b0, c});
    check_bit("cmd_slverr", 1'b0, err);
    t = done_cyc / per[v];
    if (!run) begin
      m_cnt[i] = pre;
      m_run[i] = 1'b0;
    end else if (!m_run[i] || m_var[i] != v) begin
      m_cnt[i] = pre;
      m_run[i] = 1'b1;
      m_stamp[i] = t;
    end else if (!(compat && v == 0 && i < 16)) begin
      m_cnt[i] = sat(m_cnt[i] - (t - m_stamp[i]));
      m_stamp[i] = t;
    end
    m_var[i] = v;
    e = word(i, done_cyc);
    apb(1'b0, fsdt_pkg::OFS_RESULT, 32'h0000_0000);
    check_word("result", e, rd);
  endtask

  task automatic peek(input int i);
    apb(1'b1, fsdt_pkg::OFS_PEEK_SEL, i);
    apb(1'b0, fsdt_pkg::OFS_PEEK_SEL, 32'h0000_0000);
    check_word("peek_sel", {20'h0_0000, i[11:0]}, rd);
    align(P0, 3);
    apb(1'b0, fsdt_pkg::OFS_PEEK, 32'h0000_0000);
    check_word("peek", word(i, done_cyc - 1), rd);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    int p;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    apb(1'b0, fsdt_pkg::OFS_CONFIG, 32'h0000_0000);
    check_word("config", 32'h0000_0000, rd);
    // Every variant on a bank timer, random presets
    for (int v = 0; v < 3; v++) begin
      lfsr_q = lfsr_next(lfsr_q);
      p = 4 + int'(lfsr_q[2:0]);
      do_cmd(1'b0, v, 100 + v, p);
      do_cmd(1'b1, v, 100 + v, p);
      wait_ticks(v, 3);
      do_cmd(1'b1, v, 100 + v, p);
      wait_ticks(v, 1);
      do_cmd(1'b1, v, 100 + v, p);
      wait_ticks(v, 12);
      do_cmd(1'b1, v, 100 + v, p);
      do_cmd(1'b0, v, 100 + v, int'(lfsr_q[31:16]));
    end
    do_cmd(1'b1, 1, 4095, 0);
    do_cmd(1'b1, 1, 4095, 0);
    // Low timer runs alone, high timer waits for operations
    do_cmd(1'b1, 0, 15, 10);
    wait_ticks(0, 4);
    peek(15);
    do_cmd(1'b1, 0, 16, 10);
    wait_ticks(0, 3);
    peek(16);
    // Compatibility option: count moves only at cycle end
    apb(1'b1, fsdt_pkg::OFS_CONFIG, 32'h0000_0001);
    compat = 1'b1;
    apb(1'b0, fsdt_pkg::OFS_CONFIG, 32'h0000_0000);
    check_word("config", 32'h0000_0001, rd);
    do_cmd(1'b1, 0, 0, 9);
    wait_ticks(0, 3);
    do_cmd(1'b1, 0, 0, 9);
    align(P0, 4);
    apb(1'b1, fsdt_pkg::OFS_CYCLE_END, lfsr_q);
    m_cnt[0] = sat(m_cnt[0] - (done_cyc / P0 - m_stamp[0]));
    m_stamp[0] = done_cyc / P0;
    peek(0);
    do_cmd(1'b0, 0, 0, 9);
    apb(1'b1, fsdt_pkg::OFS_CONFIG, 32'h0000_0000);
    compat = 1'b0;
    // Timer 0 left alone runs down on its own and rests at zero
    do_cmd(1'b1, 0, 0, 3);
    wait_ticks(0, 6);
    peek(0);
    // Refusals: unmapped place and bad variant
    apb(1'b0, 8'h18, 32'h0000_0000);
    check_bit("slverr", 1'b1, err);
    check_word("unmapped", 32'h0000_0000, rd);
    apb(1'b1, fsdt_pkg::OFS_CMD, 32'h3000_0005);
    check_bit("slverr", 1'b1, err);
    conclude();
  end

  // Hang guard
  initial begin
    repeat (90000) @(posedge clk);
    fails++;
    conclude();
  end
endmodule
`default_nettype wire
